// File: rcel_consts.svh
// constants of the reset-cause and error-log register bank
`ifndef RCEL_CONSTS_SVH
`define RCEL_CONSTS_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define RCEL_OFF_CLEAR     8'h00
`define RCEL_OFF_SCRATCH_BOOT_FLAGS  8'h01
`define RCEL_OFF_SCRATCH_GENERAL  8'h02
`define RCEL_OFF_CAUSE     8'h03
`define RCEL_OFF_REASON    8'h04
`define RCEL_OFF_SNAPSHOT  8'h05

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define RCEL_RESET_BYTE    8'h00
`define RCEL_RESET_SEVEN   7'h00
`define RCEL_UNMAPPED_READ 8'h00

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define RCEL_CLEAR_BIT     0
`define RCEL_BOOT_EN_BIT   0
`define RCEL_CAUSE_SHIP    0
`define RCEL_CAUSE_BOOT    1
`define RCEL_CAUSE_WDOG    2
`define RCEL_CAUSE_HOLD    3
`define RCEL_CAUSE_HEAT    4
`define RCEL_CAUSE_SUPPLY  5
`define RCEL_CAUSE_SOFT    6
`define RCEL_REASON_THERM  0
`define RCEL_REASON_BSENSE 1
`define RCEL_REASON_BLOW   2
`define RCEL_REASON_TRVOLT 3
`define RCEL_REASON_MEAS   4
`define RCEL_REASON_CHARGE 5
`define RCEL_REASON_TRTIME 6

`endif

// File: rcel_pkg.sv
// types of the reset-cause and error-log register bank
package rcel_pkg;

  // ----------------------------------------------------------------
  // register bank state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] scratch_boot_flags;
    logic [7:0] scratch_general;
    logic [6:0] cause;
    logic [6:0] reason;
    logic [7:0] snap;
    logic [7:0] rdata;
    logic       rvalid;
  } rcel_state_t;

  // ----------------------------------------------------------------
  // two-stage synchroniser state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] stage1;
    logic [7:0] stage2;
  } rcel_sync_t;

endpackage : rcel_pkg

// File: rcel_sync2.sv
// two flip-flop synchroniser for the charger comparator levels
module rcel_sync2 (
  input  wire logic       clk_sys_in,
  input  wire logic       rst_in,
  input  wire logic [7:0] async_in,
  output logic      [7:0] sync_out
);

  rcel_pkg::rcel_sync_t st;
  rcel_pkg::rcel_sync_t next_st;

  // stage1 is read only by stage2
  always_comb begin
    next_st        = st;
    next_st.stage1 = async_in;
    next_st.stage2 = st.stage1;
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_bit
      assign sync_out[gi] = st.stage2[gi];
    end
  endgenerate

endmodule : rcel_sync2

// File: rcel_reset_cause_error_log.sv
// reset-cause, charger error log and scratch register bank
`include "rcel_consts.svh"

module rcel_reset_cause_error_log (
  input  wire logic       clk_sys_in,
  input  wire logic       rst_in,
  // register port behind the two-wire interface
  input  wire logic [7:0] reg_addr_in,
  input  wire logic [7:0] reg_wdata_in,
  input  wire logic       reg_wr_in,
  input  wire logic       reg_rd_in,
  output logic      [7:0] reg_rdata_out,
  output logic            reg_rvalid_out,
  // reset cause pulses from the reset controller
  input  wire logic       ship_leave_cause_in,
  input  wire logic       boot_guard_expiry_cause_in,
  input  wire logic       watchdog_cause_in,
  input  wire logic       hold_button_cause_in,
  input  wire logic       overheat_trip_in,
  input  wire logic       supply_low_cause_in,
  input  wire logic       software_reset_cause_in,
  input  wire logic       thermal_cooling_in,
  // charger state machine error report
  input  wire logic       charger_error_in,
  input  wire logic       thermistor_fault_in,
  input  wire logic       battery_sense_fault_in,
  input  wire logic       battery_low_fault_in,
  input  wire logic       trickle_level_fault_in,
  input  wire logic       measurement_expiry_fault_in,
  input  wire logic       charge_expiry_fault_in,
  input  wire logic       trickle_expiry_fault_in,
  // charger comparator levels, asynchronous
  input  wire logic       snap_therm_cold_in,
  input  wire logic       snap_therm_cool_in,
  input  wire logic       snap_therm_warm_in,
  input  wire logic       snap_therm_hot_in,
  input  wire logic       snap_termination_level_in,
  input  wire logic       snap_recharge_level_in,
  input  wire logic       snap_trickle_level_in,
  input  wire logic       snap_battery_low_in,
  // boot monitor timer enable
  output logic            boot_monitor_enable_out
);

  // ----------------------------------------------------------------
  // decode helper
  // ----------------------------------------------------------------
  function automatic logic rcel_hit(input logic [7:0] addr,
                                    input logic [7:0] offs);
    rcel_hit = (addr == offs);
  endfunction : rcel_hit

  // ----------------------------------------------------------------
  // comparator synchroniser
  // ----------------------------------------------------------------
  logic [7:0] snap_raw;
  logic [7:0] snap_sync;

  assign snap_raw = {snap_battery_low_in,
                     snap_trickle_level_in,
                     snap_recharge_level_in,
                     snap_termination_level_in,
                     snap_therm_hot_in,
                     snap_therm_warm_in,
                     snap_therm_cool_in,
                     snap_therm_cold_in};

  rcel_sync2 u_snap_sync (
    .clk_sys_in (clk_sys_in),
    .rst_in     (rst_in),
    .async_in   (snap_raw),
    .sync_out   (snap_sync)
  );

  // ----------------------------------------------------------------
  // event decode
  // ----------------------------------------------------------------
  logic       wr_clear;
  logic       wr_scratch_boot_flags;
  logic       wr_scratch_general;
  logic       supply_over_heat;
  logic [6:0] cause_set;
  logic [6:0] reason_set;

  assign wr_clear    = reg_wr_in
                     && rcel_hit(reg_addr_in, `RCEL_OFF_CLEAR)
                     && reg_wdata_in[`RCEL_CLEAR_BIT];
  assign wr_scratch_boot_flags = reg_wr_in
                     && rcel_hit(reg_addr_in, `RCEL_OFF_SCRATCH_BOOT_FLAGS);
  assign wr_scratch_general = reg_wr_in
                     && rcel_hit(reg_addr_in, `RCEL_OFF_SCRATCH_GENERAL);

  // a supply drop while cooling masks the concurrent overheat report
  assign supply_over_heat = supply_low_cause_in
                          && thermal_cooling_in;

  always_comb begin
    cause_set = `RCEL_RESET_SEVEN;
    cause_set[`RCEL_CAUSE_SHIP]   = ship_leave_cause_in;
    cause_set[`RCEL_CAUSE_BOOT]   = boot_guard_expiry_cause_in;
    cause_set[`RCEL_CAUSE_WDOG]   = watchdog_cause_in;
    cause_set[`RCEL_CAUSE_HOLD]   = hold_button_cause_in;
    cause_set[`RCEL_CAUSE_HEAT]   = overheat_trip_in
                                  && !supply_over_heat;
    cause_set[`RCEL_CAUSE_SUPPLY] = supply_low_cause_in;
    cause_set[`RCEL_CAUSE_SOFT]   = software_reset_cause_in;
  end

  always_comb begin
    reason_set = `RCEL_RESET_SEVEN;
    if (charger_error_in) begin
      reason_set[`RCEL_REASON_THERM]  = thermistor_fault_in;
      reason_set[`RCEL_REASON_BSENSE] = battery_sense_fault_in;
      reason_set[`RCEL_REASON_BLOW]   = battery_low_fault_in;
      reason_set[`RCEL_REASON_TRVOLT] = trickle_level_fault_in;
      reason_set[`RCEL_REASON_MEAS]   = measurement_expiry_fault_in;
      reason_set[`RCEL_REASON_CHARGE] = charge_expiry_fault_in;
      reason_set[`RCEL_REASON_TRTIME] = trickle_expiry_fault_in;
    end
  end

  // ----------------------------------------------------------------
  // register bank state
  // ----------------------------------------------------------------
  rcel_pkg::rcel_state_t st;
  rcel_pkg::rcel_state_t next_st;

  always_comb begin
    next_st        = st;
    next_st.rvalid = reg_rd_in;
    // set wins over a clear in the same cycle
    next_st.cause  = (wr_clear ? `RCEL_RESET_SEVEN : st.cause)
                   | cause_set;
    next_st.reason = (wr_clear ? `RCEL_RESET_SEVEN : st.reason)
                   | reason_set;
    if (charger_error_in) begin
      next_st.snap = snap_sync;
    end else if (wr_clear) begin
      next_st.snap = `RCEL_RESET_BYTE;
    end
    if (wr_scratch_boot_flags) begin
      next_st.scratch_boot_flags = reg_wdata_in;
    end
    if (wr_scratch_general) begin
      next_st.scratch_general = reg_wdata_in;
    end
    if (reg_rd_in) begin
      unique case (reg_addr_in)
        `RCEL_OFF_CLEAR:    next_st.rdata = `RCEL_RESET_BYTE;
        `RCEL_OFF_SCRATCH_BOOT_FLAGS: next_st.rdata = st.scratch_boot_flags;
        `RCEL_OFF_SCRATCH_GENERAL: next_st.rdata = st.scratch_general;
        `RCEL_OFF_CAUSE:    next_st.rdata = {1'b0, st.cause};
        `RCEL_OFF_REASON:   next_st.rdata = {1'b0, st.reason};
        `RCEL_OFF_SNAPSHOT: next_st.rdata = st.snap;
        default:            next_st.rdata = `RCEL_UNMAPPED_READ;
      endcase
    end
  end

  // rst_in is the power-on reset; no other reset reaches this bank
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign reg_rdata_out           = st.rdata;
  assign reg_rvalid_out          = st.rvalid;
  assign boot_monitor_enable_out = st.scratch_boot_flags[`RCEL_BOOT_EN_BIT];

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);

  logic any_cause;
  assign any_cause = |cause_set;

  clear_all_a: assert property (
    (wr_clear && !any_cause && !charger_error_in)
    |=> (st.cause == 7'h00) && (st.reason == 7'h00) && (st.snap == 8'h00))
    else $error("log clear left a log non-zero");

  ship_flag_a: assert property (
    ship_leave_cause_in |=> st.cause[0] [*2])
    else $error("ship leave cause not held");

  boot_flag_a: assert property (
    boot_guard_expiry_cause_in |=> st.cause[1])
    else $error("boot monitor cause not set");

  wdog_flag_a: assert property (
    watchdog_cause_in |=> st.cause[2])
    else $error("watchdog cause not set");

  hold_flag_a: assert property (
    hold_button_cause_in |=> st.cause[3])
    else $error("long press cause not set");

  heat_flag_a: assert property (
    (overheat_trip_in && !thermal_cooling_in) |=> st.cause[4])
    else $error("thermal cause not set");

  supply_flag_a: assert property (
    supply_low_cause_in |=> st.cause[5])
    else $error("supply low cause not set");

  soft_flag_a: assert property (
    software_reset_cause_in |=> st.cause[6])
    else $error("software reset cause not set");

  cool_mask_a: assert property (
    (overheat_trip_in && supply_low_cause_in && thermal_cooling_in
     && (st.cause[4] == 1'b0))
    |=> !st.cause[4] && st.cause[5])
    else $error("overheat recorded during cooling supply drop");

  boot_enable_a: assert property (
    wr_scratch_boot_flags |=> boot_monitor_enable_out == $past(reg_wdata_in[0]))
    else $error("boot monitor enable not written");

  scratch_hold_a: assert property (
    !wr_scratch_general |=> $stable(st.scratch_general))
    else $error("scratch_general changed without a write");

  reason_cap_a: assert property (
    (charger_error_in && charge_expiry_fault_in) |=> st.reason[5])
    else $error("charge timeout reason not captured");

  snap_cap_a: assert property (
    charger_error_in |=> st.snap == $past(snap_sync))
    else $error("comparator snapshot not captured");

  cause_ro_a: assert property (
    (reg_wr_in && rcel_hit(reg_addr_in, `RCEL_OFF_CAUSE) && !any_cause)
    |=> $stable(st.cause))
    else $error("host write changed the cause log");

  cause_read_a: assert property (
    (reg_rd_in && rcel_hit(reg_addr_in, `RCEL_OFF_CAUSE))
    |=> reg_rvalid_out && reg_rdata_out == {1'b0, $past(st.cause)})
    else $error("cause read returned wrong layout");

  clear_read_a: assert property (
    (reg_rd_in && rcel_hit(reg_addr_in, `RCEL_OFF_CLEAR))
    |=> reg_rdata_out == 8'h00)
    else $error("clear register read not zero");

  clear_seen_c: cover property (wr_clear ##1 st.cause == 7'h00);
  set_vs_clr_c: cover property (wr_clear && any_cause);
  snap_err_c:   cover property (charger_error_in ##1 st.snap != 8'h00);
  boot_on_c:    cover property (wr_scratch_boot_flags ##1 boot_monitor_enable_out);

endmodule : rcel_reset_cause_error_log

// File: rcel_event_src.sv
// reset controller and charger source model driving the log bank events
module rcel_event_src (
  input  wire logic       clk_sys_in,
  input  wire logic       rst_in,
  input  wire logic [6:0] cause_req_in,
  input  wire logic       cooling_req_in,
  input  wire logic       chg_req_in,
  input  wire logic [6:0] fault_req_in,
  input  wire logic [7:0] level_req_in,
  output logic      [6:0] cause_out,
  output logic            cooling_out,
  output logic            chg_out,
  output logic      [6:0] fault_out,
  output logic      [7:0] level_out
);
  timeunit 1ns;
  timeprecision 1ps;

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      cause_out   <= 7'h00;
      cooling_out <= 1'b0;
      chg_out     <= 1'b0;
      fault_out   <= 7'h00;
      level_out   <= 8'h00;
    end else begin
      cause_out   <= cause_req_in;
      cooling_out <= cooling_req_in;
      chg_out     <= chg_req_in;
      level_out   <= level_req_in;
      // faults only mean something with the error pulse; else they toggle
      fault_out   <= chg_req_in ? fault_req_in : ~fault_out;
    end
  end
endmodule : rcel_event_src

// File: rcel_reset_cause_error_log_bench.sv
// self-checking bench of the reset-cause and error-log register bank
`include "rcel_consts.svh"
module rcel_reset_cause_error_log_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic       wr = 1'b0;
  logic       rd = 1'b0;
  logic [7:0] rdata;
  logic       rvalid;
  logic       boot_en;
  logic [6:0] cause_req = 7'h00;
  logic       cool_req = 1'b0;
  logic       chg_req = 1'b0;
  logic [6:0] fault_req = 7'h00;
  logic [7:0] level_req = 8'h00;
  logic [6:0] cause;
  logic       cool;
  logic       chg;
  logic [6:0] fault;
  logic [7:0] level;
  int         err_total = 0;
  int         check_count = 0;

  always #4 clk = ~clk;

  rcel_event_src src (.clk_sys_in(clk), .rst_in(rst),
    .cause_req_in(cause_req), .cooling_req_in(cool_req),
    .chg_req_in(chg_req), .fault_req_in(fault_req),
    .level_req_in(level_req), .cause_out(cause), .cooling_out(cool),
    .chg_out(chg), .fault_out(fault), .level_out(level));

  rcel_reset_cause_error_log DUT (.clk_sys_in(clk), .rst_in(rst),
    .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr),
    .reg_rd_in(rd), .reg_rdata_out(rdata), .reg_rvalid_out(rvalid),
    .ship_leave_cause_in(cause[0]), .boot_guard_expiry_cause_in(cause[1]),
    .watchdog_cause_in(cause[2]), .hold_button_cause_in(cause[3]),
    .overheat_trip_in(cause[4]), .supply_low_cause_in(cause[5]),
    .software_reset_cause_in(cause[6]), .thermal_cooling_in(cool),
    .charger_error_in(chg), .thermistor_fault_in(fault[0]),
    .battery_sense_fault_in(fault[1]), .battery_low_fault_in(fault[2]),
    .trickle_level_fault_in(fault[3]),
    .measurement_expiry_fault_in(fault[4]),
    .charge_expiry_fault_in(fault[5]), .trickle_expiry_fault_in(fault[6]),
    .snap_therm_cold_in(level[0]), .snap_therm_cool_in(level[1]),
    .snap_therm_warm_in(level[2]), .snap_therm_hot_in(level[3]),
    .snap_termination_level_in(level[4]),
    .snap_recharge_level_in(level[5]), .snap_trickle_level_in(level[6]),
    .snap_battery_low_in(level[7]), .boot_monitor_enable_out(boot_en));

  // ----------------------------------------------------------------
  // access and compare tasks
  // ----------------------------------------------------------------
  task automatic check8(input string what, input logic [7:0] exp,
                        input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : check8

  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : reg_write

  task automatic reg_read(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    check8("read valid", 8'h01, {7'h00, rvalid});
    check8($sformatf("read at %h", a), exp, rdata);
  endtask : reg_read

  task automatic pulse(input logic [6:0] c, input logic e,
                       input logic [6:0] f);
    @(posedge clk);
    cause_req <= c;
    chg_req   <= e;
    fault_req <= f;
    @(posedge clk);
    cause_req <= 7'h00;
    chg_req   <= 1'b0;
    repeat (2) @(posedge clk);
  endtask : pulse

  task automatic wrap_up;
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : wrap_up

  // ----------------------------------------------------------------
  // test sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      reg_read(8'(i), 8'h00);
    end
    reg_read(8'hFF, 8'h00);
    check8("boot enable", 8'h00, {7'h00, boot_en});
    for (int i = 0; i < 7; i++) begin
      pulse(7'h01 << i, 1'b0, 7'h00);
      reg_read(`RCEL_OFF_CAUSE,
               {1'b0, 7'h01 << i});
      reg_write(`RCEL_OFF_CLEAR, 8'h01);
      reg_read(`RCEL_OFF_CAUSE, 8'h00);
    end
    pulse(7'h04, 1'b0, 7'h00);
    pulse(7'h40, 1'b0, 7'h00);
    reg_write(`RCEL_OFF_CLEAR, 8'hFE);
    reg_write(`RCEL_OFF_CAUSE, 8'h00);
    reg_read(`RCEL_OFF_CAUSE, 8'h44);
    reg_write(`RCEL_OFF_CLEAR, 8'h01);
    cool_req <= 1'b1;
    pulse(7'h30, 1'b0, 7'h00);
    cool_req <= 1'b0;
    reg_read(`RCEL_OFF_CAUSE, 8'h20);
    pulse(7'h10, 1'b0, 7'h00);
    reg_read(`RCEL_OFF_CAUSE, 8'h30);
    // scratch storage and the boot monitor enable
    reg_write(`RCEL_OFF_SCRATCH_BOOT_FLAGS, 8'hA5);
    reg_write(`RCEL_OFF_SCRATCH_GENERAL, 8'h5A);
    check8("boot enable", 8'h01, {7'h00, boot_en});
    reg_write(`RCEL_OFF_CLEAR, 8'h01);
    reg_read(`RCEL_OFF_SCRATCH_BOOT_FLAGS, 8'hA5);
    reg_read(`RCEL_OFF_SCRATCH_GENERAL, 8'h5A);
    reg_write(`RCEL_OFF_SCRATCH_BOOT_FLAGS, 8'hA4);
    reg_read(`RCEL_OFF_SCRATCH_BOOT_FLAGS, 8'hA4);
    check8("boot enable", 8'h00, {7'h00, boot_en});
    // charger errors: reason accumulates, snapshot is overwritten
    level_req <= 8'hC3;
    repeat (4) @(posedge clk);
    pulse(7'h00, 1'b1, 7'h55);
    reg_read(`RCEL_OFF_REASON, 8'h55);
    reg_read(`RCEL_OFF_SNAPSHOT, 8'hC3);
    level_req <= 8'h3C;
    repeat (4) @(posedge clk);
    pulse(7'h01, 1'b1, 7'h2A);
    reg_write(`RCEL_OFF_SNAPSHOT, 8'hFF);
    reg_read(`RCEL_OFF_REASON, 8'h7F);
    reg_read(`RCEL_OFF_SNAPSHOT, 8'h3C);
    reg_write(`RCEL_OFF_CLEAR, 8'h01);
    reg_read(`RCEL_OFF_CAUSE, 8'h00);
    reg_read(`RCEL_OFF_REASON, 8'h00);
    reg_read(`RCEL_OFF_SNAPSHOT, 8'h00);
    // power-on reset in mid-run empties the scratch storage
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    reg_read(`RCEL_OFF_SCRATCH_BOOT_FLAGS, 8'h00);
    reg_read(`RCEL_OFF_SCRATCH_GENERAL, 8'h00);
    wrap_up();
  end

  initial begin
    repeat (5000) @(posedge clk);
    err_total++;
    wrap_up();
  end
endmodule : rcel_reset_cause_error_log_bench
